// file: hw/tci_params.svh
// named constants for the touch controller host port
// assumes a 100 MHz core clock and an open-drain bus resolved outside
`ifndef TCI_PARAMS_SVH
`define TCI_PARAMS_SVH
`define TCI_DEV_ADDR 7'h56
`define TCI_EXT_HI 8'hE0
`define TCI_TERM_ADDR 8'hFF
`define TCI_TERM_VAL 8'h00
`define TCI_INFO_ADDR 8'h0F
`define TCI_TIMEOUT_ADDR 8'h32
`define TCI_SYSCTL_ADDR 8'h33
`define TCI_ACK_BIT 0
`define TCI_SUSPEND_BIT 1
`define TCI_SOFT_RST_BIT 2
`define TCI_MAP_WORDS 64
`define TCI_EXT_WORDS 16
`define TCI_TIMEOUT_RST 16'h0064
`define TCI_CLK_PERIOD_NS 10
`define TCI_MS_NS 1000000
`define TCI_CYCLE_MS 10
`endif

// file: hw/tci_pkg.sv
// state types for the touch controller host port
// assumes tci_params.svh is on the include path
`default_nettype none
package tci_pkg;
  typedef enum logic [2:0] {TCI_ST_IDLE, TCI_ST_ADDR, TCI_ST_AACK, TCI_ST_WR, TCI_ST_WACK, TCI_ST_RD,
                            TCI_ST_RACK} tci_bus_st_t;
  typedef enum logic [1:0] {TCI_W_PROC, TCI_W_OPEN, TCI_W_SUSP} tci_win_st_t;
endpackage : tci_pkg
`default_nettype wire

// file: hw/tci_host_port.sv
// two-wire target port with ready line, window control and event gating
// assumes scl/sda/ready wires are resolved outside from the enables; event inputs are clk-domain pulses
`default_nettype none
`include "tci_params.svh"
module tci_host_port
  import tci_pkg::*;
#(
  parameter int MS_CYCLES = `TCI_MS_NS / `TCI_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic rdy_out,
  output logic rdy_oe,
  input wire logic event_mode_en,
  input wire logic comms_end_cmd,
  input wire logic comms_req_en,
  input wire logic gesture_window_trigger_en,
  input wire logic pad_motion_window_trigger_en,
  input wire logic channel_state_window_trigger_en,
  input wire logic retune_window_trigger_en,
  input wire logic lowpower_channel_trigger_en,
  input wire logic gesture_evt,
  input wire logic pad_motion_evt,
  input wire logic channel_state_evt,
  input wire logic [1:0] retune_evt,
  input wire logic lowpower_channel_evt,
  output logic show_reset,
  output logic [1:0] retune_done_flags,
  output logic soft_restart_command,
  output logic suspended
);
  // double-flop the pins; the third stage only serves edge detection
  logic scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_in, sda_s1_r, sda_s2_r};
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  assign bus_start = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
  assign bus_stop = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;

  // word storage; the map holds no reset so only control state below is defined at reset
  logic [15:0] map_mem [`TCI_MAP_WORDS];
  logic [15:0] ext_mem [`TCI_EXT_WORDS];
  logic [15:0] sysctl_r, sysctl_nxt, timeout_r, timeout_nxt;
  logic show_reset_r, show_reset_nxt;
  logic [1:0] retune_r, retune_nxt;

  function automatic logic tci_in_map(input logic [15:0] a);
    return a < 16'(`TCI_MAP_WORDS);
  endfunction : tci_in_map
  function automatic logic tci_in_ext(input logic [15:0] a);
    return (a[15:8] == `TCI_EXT_HI) && (a[7:0] < 8'(`TCI_EXT_WORDS));
  endfunction : tci_in_ext

  // read mux; unmapped words read as zero
  logic [15:0] ptr_r, ptr_nxt, rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (ptr_r == {8'h00, `TCI_SYSCTL_ADDR}) rd_word = sysctl_r;
    else if (ptr_r == {8'h00, `TCI_TIMEOUT_ADDR}) rd_word = timeout_r;
    else if (ptr_r == {8'h00, `TCI_INFO_ADDR}) rd_word = {13'h0000, show_reset_r, retune_r};
    else if (tci_in_map(ptr_r)) rd_word = map_mem[ptr_r[5:0]];
    else if (tci_in_ext(ptr_r)) rd_word = ext_mem[ptr_r[3:0]];
  end

  // bus engine state
  tci_bus_st_t st_r, st_nxt;
  tci_win_st_t wst_r, wst_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, lo_r, lo_nxt;
  logic [1:0] widx_r, widx_nxt;
  logic rw_r, rw_nxt, phase_r, phase_nxt;
  logic sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
  logic we, ctl_we, tmo_we, term_hit, req_hit, addr_hit, aack_go, byte_done;
  logic [15:0] wdata;
  logic [7:0] rx_byte;
  assign rx_byte = sh_r;
  assign aack_go = (st_r == TCI_ST_AACK) && (scl_fall || (scl_oe_r && wst_r == TCI_W_OPEN));
  assign byte_done = scl_fall && (cnt_r == 4'h8);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    lo_nxt = lo_r;
    widx_nxt = widx_r;
    rw_nxt = rw_r;
    phase_nxt = phase_r;
    ptr_nxt = ptr_r;
    sda_oe_nxt = sda_oe_r;
    scl_oe_nxt = scl_oe_r;
    we = 1'b0;
    ctl_we = 1'b0;
    tmo_we = 1'b0;
    term_hit = 1'b0;
    req_hit = 1'b0;
    addr_hit = 1'b0;
    wdata = {rx_byte, lo_r};
    if (bus_stop) begin
      st_nxt = TCI_ST_IDLE;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
    end else if (bus_start) begin
      st_nxt = TCI_ST_ADDR;
      cnt_nxt = 4'h0;
      widx_nxt = 2'h0;
      phase_nxt = 1'b0; // a repeated start re-reads the current word from byte 0
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        TCI_ST_IDLE: ;
        TCI_ST_ADDR, TCI_ST_WR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s2_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done && st_r == TCI_ST_ADDR) begin
            if (sh_r[7:1] == `TCI_DEV_ADDR) begin
              st_nxt = TCI_ST_AACK;
              rw_nxt = sh_r[0];
              addr_hit = 1'b1;
              sda_oe_nxt = 1'b1;
            end else begin
              st_nxt = TCI_ST_IDLE;
            end
          end else if (byte_done) begin
            st_nxt = TCI_ST_WACK;
            sda_oe_nxt = 1'b1;
            if (widx_r == 2'h0) begin
              ptr_nxt = (rx_byte == `TCI_EXT_HI) ? {rx_byte, 8'h00} : {8'h00, rx_byte};
              widx_nxt = (rx_byte == `TCI_EXT_HI) ? 2'h1 : 2'h2;
              phase_nxt = 1'b0;
            end else if (widx_r == 2'h1) begin
              ptr_nxt = {ptr_r[15:8], rx_byte};
              widx_nxt = 2'h2;
            end else if (!phase_r) begin
              lo_nxt = rx_byte;
              phase_nxt = 1'b1;
              if (ptr_r == {8'h00, `TCI_TERM_ADDR} && rx_byte == `TCI_TERM_VAL) begin
                term_hit = (wst_r == TCI_W_OPEN);
                req_hit = (wst_r != TCI_W_OPEN) && comms_req_en;
              end
            end else begin
              phase_nxt = 1'b0;
              ptr_nxt = ptr_r + 16'h0001;
              if (wst_r == TCI_W_OPEN) begin
                ctl_we = (ptr_r == {8'h00, `TCI_SYSCTL_ADDR});
                tmo_we = (ptr_r == {8'h00, `TCI_TIMEOUT_ADDR});
                we = ~ctl_we & ~tmo_we;
              end
            end
          end
        end
        TCI_ST_AACK: begin
          if (aack_go && wst_r != TCI_W_OPEN && !comms_req_en) begin
            scl_oe_nxt = 1'b1;
          end else if (aack_go) begin
            scl_oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            if (rw_r) begin
              st_nxt = TCI_ST_RD;
              sh_nxt = phase_r ? rd_word[15:8] : rd_word[7:0];
              sda_oe_nxt = phase_r ? ~rd_word[15] : ~rd_word[7];
              phase_nxt = ~phase_r;
              if (phase_r) ptr_nxt = ptr_r + 16'h0001;
            end else begin
              st_nxt = TCI_ST_WR;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        TCI_ST_WACK: begin
          if (scl_fall) begin
            st_nxt = TCI_ST_WR;
            cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
          end
        end
        TCI_ST_RD: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (byte_done) begin
            st_nxt = TCI_ST_RACK;
            sda_oe_nxt = 1'b0;
          end else if (scl_fall) begin
            sh_nxt = {sh_r[6:0], 1'b0};
            sda_oe_nxt = ~sh_r[6];
          end
        end
        TCI_ST_RACK: begin
          if (scl_rise && sda_s2_r) begin
            st_nxt = TCI_ST_IDLE; // master nack ends the read
          end else if (scl_fall) begin
            st_nxt = TCI_ST_RD;
            cnt_nxt = 4'h0;
            sh_nxt = phase_r ? rd_word[15:8] : rd_word[7:0];
            sda_oe_nxt = phase_r ? ~rd_word[15] : ~rd_word[7];
            phase_nxt = ~phase_r;
            if (phase_r) ptr_nxt = ptr_r + 16'h0001;
          end
        end
        default: st_nxt = TCI_ST_IDLE; // the eighth code is unused; fall back to idle
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= TCI_ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      lo_r <= 8'h00;
      widx_r <= 2'h0;
      rw_r <= 1'b0;
      phase_r <= 1'b0;
      ptr_r <= 16'h0000;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      lo_r <= lo_nxt;
      widx_r <= widx_nxt;
      rw_r <= rw_nxt;
      phase_r <= phase_nxt;
      ptr_r <= ptr_nxt;
      sda_oe_r <= sda_oe_nxt;
      scl_oe_r <= scl_oe_nxt;
    end
  end

  // word writes land only inside an open window
  always_ff @(posedge clk) begin
    if (we && tci_in_map(ptr_r)) map_mem[ptr_r[5:0]] <= wdata;
    if (we && tci_in_ext(ptr_r)) ext_mem[ptr_r[3:0]] <= wdata;
  end

  // window control: processing ticks, timeout, close conditions, session-end actions
  logic [16:0] ms_cnt_r, ms_cnt_nxt;
  logic [7:0] cyc_ms_r, cyc_ms_nxt;
  logic [15:0] tmo_ms_r, tmo_ms_nxt;
  logic evt_pend_r, evt_pend_nxt, req_pend_r, req_pend_nxt, term_r, term_nxt;
  logic serviced_r, serviced_nxt, soft_rst_r, soft_rst_nxt;
  logic ms_tick, cycle_tick, evt_mode, evt_hit, timeout_hit, win_close, ack_wr;
  assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));
  assign cycle_tick = ms_tick && (cyc_ms_r == 8'(`TCI_CYCLE_MS - 1));
  assign evt_mode = event_mode_en && !show_reset_r;
  assign evt_hit = (gesture_evt && gesture_window_trigger_en)
                 || (pad_motion_evt && pad_motion_window_trigger_en)
                 || (channel_state_evt && channel_state_window_trigger_en)
                 || ((|retune_evt) && retune_window_trigger_en)
                 || (lowpower_channel_evt && lowpower_channel_trigger_en);
  assign timeout_hit = !serviced_r && (timeout_r != 16'h0000) && (tmo_ms_r >= timeout_r);
  assign win_close = (wst_r == TCI_W_OPEN)
                   && (timeout_hit
                       || (bus_stop && !comms_end_cmd)
                       || (bus_stop && (term_r || term_hit)));
  assign ack_wr = ctl_we && wdata[`TCI_ACK_BIT];

  always_comb begin
    wst_nxt = wst_r;
    ms_cnt_nxt = ms_tick ? 17'h00000 : ms_cnt_r + 17'h00001;
    cyc_ms_nxt = cycle_tick ? 8'h00 : (ms_tick ? cyc_ms_r + 8'h01 : cyc_ms_r);
    tmo_ms_nxt = (wst_r != TCI_W_OPEN) ? 16'h0000 : (ms_tick ? tmo_ms_r + 16'h0001 : tmo_ms_r);
    evt_pend_nxt = evt_pend_r || evt_hit;
    req_pend_nxt = req_pend_r || req_hit;
    term_nxt = term_r || term_hit;
    // a stretched access that the opening window releases also counts as service
    serviced_nxt = serviced_r || (addr_hit && wst_r == TCI_W_OPEN) || (scl_oe_r && wst_r == TCI_W_OPEN);
    sysctl_nxt = ctl_we ? {wdata[15:1], 1'b0} : sysctl_r; // ack bit is a strobe, never stored
    timeout_nxt = tmo_we ? wdata : timeout_r;
    show_reset_nxt = ack_wr ? 1'b0 : show_reset_r;
    retune_nxt = retune_r;
    soft_rst_nxt = 1'b0;
    unique case (wst_r)
      TCI_W_PROC: begin
        if (cycle_tick && (!evt_mode || evt_pend_r || evt_hit || req_pend_r || scl_oe_r)) begin
          wst_nxt = TCI_W_OPEN;
          evt_pend_nxt = 1'b0;
          req_pend_nxt = 1'b0;
        end
      end
      TCI_W_OPEN: begin
        if (win_close) begin
          term_nxt = 1'b0;
          serviced_nxt = 1'b0;
          retune_nxt = 2'h0; // flags last exactly one window
          wst_nxt = sysctl_nxt[`TCI_SUSPEND_BIT] ? TCI_W_SUSP : TCI_W_PROC;
          if (sysctl_nxt[`TCI_SOFT_RST_BIT]) begin
            soft_rst_nxt = 1'b1;
            show_reset_nxt = 1'b1;
            sysctl_nxt = 16'h0000;
            timeout_nxt = `TCI_TIMEOUT_RST;
            evt_pend_nxt = 1'b0;
            wst_nxt = TCI_W_PROC;
          end
        end
      end
      TCI_W_SUSP: begin
        if (scl_oe_r || req_pend_r) begin
          wst_nxt = TCI_W_OPEN; // forced comms wakes
          req_pend_nxt = 1'b0;
        end
      end
      default: wst_nxt = TCI_W_PROC;
    endcase
    if (retune_window_trigger_en) retune_nxt = retune_nxt | retune_evt; // set wins over clear
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wst_r <= TCI_W_PROC;
      ms_cnt_r <= 17'h00000;
      cyc_ms_r <= 8'h00;
      tmo_ms_r <= 16'h0000;
      evt_pend_r <= 1'b0;
      req_pend_r <= 1'b0;
      term_r <= 1'b0;
      serviced_r <= 1'b0;
      sysctl_r <= 16'h0000;
      timeout_r <= `TCI_TIMEOUT_RST;
      show_reset_r <= 1'b1;
      retune_r <= 2'h0;
      soft_rst_r <= 1'b0;
    end else begin
      wst_r <= wst_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      cyc_ms_r <= cyc_ms_nxt;
      tmo_ms_r <= tmo_ms_nxt;
      evt_pend_r <= evt_pend_nxt;
      req_pend_r <= req_pend_nxt;
      term_r <= term_nxt;
      serviced_r <= serviced_nxt;
      sysctl_r <= sysctl_nxt;
      timeout_r <= timeout_nxt;
      show_reset_r <= show_reset_nxt;
      retune_r <= retune_nxt;
      soft_rst_r <= soft_rst_nxt;
    end
  end

  // pin and status outputs; the open-drain data levels are always low
  logic rdy_oe_r, susp_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdy_oe_r <= 1'b0;
      susp_r <= 1'b0;
    end else begin
      rdy_oe_r <= (wst_nxt == TCI_W_OPEN);
      susp_r <= (wst_nxt == TCI_W_SUSP);
    end
  end
  logic zero_r;
  always_ff @(posedge clk) zero_r <= 1'b0;
  assign scl_out = zero_r;
  assign sda_out = zero_r;
  assign rdy_out = zero_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign rdy_oe = rdy_oe_r;
  assign show_reset = show_reset_r;
  assign retune_done_flags = retune_r;
  assign soft_restart_command = soft_rst_r;
  assign suspended = susp_r;

  // checks
  a_rdy_window: assert property (@(posedge clk) disable iff (!rst_n)
    rdy_oe_r == (wst_r == TCI_W_OPEN)) else $error("ready line disagrees with window");
  a_addr_filter: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == TCI_ST_ADDR && byte_done && !bus_start && !bus_stop && sh_r[7:1] != `TCI_DEV_ADDR)
    |=> st_r == TCI_ST_IDLE && !sda_oe_r) else $error("foreign address acknowledged");
  a_stretch_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(scl_oe_r) |-> $past(wst_r) != TCI_W_OPEN && !$past(comms_req_en)) else $error("bad stretch");
  a_timeout_close: assert property (@(posedge clk) disable iff (!rst_n)
    (wst_r == TCI_W_OPEN && timeout_hit) |=> wst_r != TCI_W_OPEN) else $error("timeout kept window");
  a_stop_close: assert property (@(posedge clk) disable iff (!rst_n)
    (wst_r == TCI_W_OPEN && bus_stop && !comms_end_cmd) |=> !rdy_oe_r) else $error("stop kept window");
  a_end_cmd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (wst_r == TCI_W_OPEN && bus_stop && comms_end_cmd && !term_r && !term_hit && !timeout_hit)
    |=> wst_r == TCI_W_OPEN) else $error("window closed without terminate");
  a_event_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (wst_r == TCI_W_PROC && cycle_tick && evt_mode && !evt_pend_r && !evt_hit && !req_pend_r && !scl_oe_r)
    |=> wst_r == TCI_W_PROC) else $error("window without event");
  a_free_run: assert property (@(posedge clk) disable iff (!rst_n)
    (wst_r == TCI_W_PROC && cycle_tick && !evt_mode) |=> rdy_oe_r) else $error("cycle skipped window");
  a_reset_flag: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(show_reset_r) |-> $past(ack_wr)) else $error("reset flag cleared without ack");
  a_restart_after: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst_r |-> $past(wst_r) == TCI_W_OPEN && wst_r == TCI_W_PROC) else $error("restart outside close");
  c_event_window: cover property (@(posedge clk) disable iff (!rst_n)
    wst_r == TCI_W_PROC && evt_mode && evt_pend_r ##1 wst_r == TCI_W_OPEN);
  c_timeout: cover property (@(posedge clk) disable iff (!rst_n) wst_r == TCI_W_OPEN && timeout_hit);
  c_terminate: cover property (@(posedge clk) disable iff (!rst_n) win_close && term_r);
  c_stretch: cover property (@(posedge clk) disable iff (!rst_n) $fell(scl_oe_r));
endmodule : tci_host_port
`default_nettype wire

// file: tb/tci_i2c_master.sv
// bus master model standing in for the host microcontroller
// assumes scl_in and sda_in are resolved outside with pull-ups; this model only pulls low
`default_nettype none
module tci_i2c_master (
  input wire logic scl_in,
  input wire logic sda_in,
  output var logic scl_low,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real Q = 31.25;  // quarter of the 125 ns bus period
  // released bus at time zero: the clock stands still high between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // one bus clock; the high phase only counts once a stretch is over
  task automatic bit_io(input logic drv_low, output logic v);
    #Q sda_low = drv_low;
    #Q scl_low = 1'b0;
    wait (scl_in === 1'b1);
    #Q v = sda_in;
    #Q scl_low = 1'b1;
  endtask : bit_io
  // start and stop differ in which way data moves while the clock is high; a start then pulls the clock low, a stop leaves it high
  task automatic edge_cond(input logic is_start);
    #Q sda_low = ~is_start;
    #Q scl_low = 1'b0;
    wait (scl_in === 1'b1);
    #Q sda_low = is_start;
    #Q scl_low = is_start;
  endtask : edge_cond
  // most significant bit first, then the target's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(~b[i], v);
    bit_io(1'b0, v);
    ack = ~v;
  endtask : wbyte
  // the master acknowledges every byte but the last one it wants
  task automatic rbyte(output logic [7:0] b, input logic last);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, v);
      b[i] = v;
    end
    bit_io(~last, v);
  endtask : rbyte
endmodule : tci_i2c_master
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench: drives settings and events, talks over the bus through the master model
// assumes the design files and tb/tci_i2c_master.sv are compiled before this one
`default_nettype none
`include "tci_params.svh"
`define CMP(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MSC = 20;  // short ms keeps a 10 ms cycle at 200 clocks
  localparam logic [7:0] AW = {`TCI_DEV_ADDR, 1'b0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic event_mode_en = 1'b0;
  logic comms_end_cmd = 1'b0;
  logic comms_req_en = 1'b0;
  logic [4:0] en = 5'h1F;
  logic [5:0] evt = 6'h00;
  logic scl_out, scl_oe, sda_out, sda_oe, rdy_out, rdy_oe, show_reset, soft_restart_command, suspended;
  logic [1:0] retune_done_flags;
  logic m_scl, m_sda, k;
  logic [15:0] rw [2];
  logic [15:0] d [2];
  logic [15:0] eq [$];
  logic [15:0] gq [$];
  string nq [$];
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int e, n;
  int restarts = 0;
  string cn;
  logic [15:0] ce, cg;
  integer seed = 32'hE6AF90A6;
  // open-drain wires: the pull-up wins unless some party pulls low
  wire logic scl_in = !((scl_oe && !scl_out) || m_scl);
  wire logic sda_in = !((sda_oe && !sda_out) || m_sda);
  wire logic [3:0] st = {show_reset, soft_restart_command, suspended, rdy_oe};
  tci_host_port #(.MS_CYCLES(MSC)) i_tci_host_port (.clk, .rst_n, .scl_in, .scl_out, .scl_oe, .sda_in,
    .sda_out, .sda_oe, .rdy_out, .rdy_oe, .event_mode_en, .comms_end_cmd, .comms_req_en,
    .gesture_window_trigger_en(en[0]), .pad_motion_window_trigger_en(en[1]),
    .channel_state_window_trigger_en(en[2]), .retune_window_trigger_en(en[3]),
    .lowpower_channel_trigger_en(en[4]), .gesture_evt(evt[0]), .pad_motion_evt(evt[1]),
    .channel_state_evt(evt[2]), .retune_evt(evt[4:3]), .lowpower_channel_evt(evt[5]),
    .show_reset, .retune_done_flags, .soft_restart_command, .suspended);
  tci_i2c_master i_tci_i2c_master (.scl_in, .sda_in, .scl_low(m_scl), .sda_low(m_sda));
  // 100 MHz core clock
  initial forever #5 clk = ~clk;
  // hang guard: far past the planned length counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  // restart is a one-cycle pulse, so it is counted at every edge rather than polled
  always @(posedge clk) if (soft_restart_command === 1'b1) restarts <= restarts + 1;
  // watcher: oldest expectation against what was seen; pop once so the queues stay aligned
  initial forever begin
    wait (eq.size() != 0);
    cn = nq.pop_front();
    ce = eq.pop_front();
    cg = gq.pop_front();
    `CMP(cn, ce, cg)
  end
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    nq.push_back(nm);
    gq.push_back(got);
    eq.push_back(ex);
  endtask : chk
  // inputs driven after a tick change 1 ns after the rising edge
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_lvl(input string nm, input int s, input logic v, input int lim);
    for (int i = 0; i < lim && st[s] !== v; i++) tick(1);
    chk(nm, 16'(v), 16'(st[s]));
  endtask : wait_lvl
  task automatic send(input logic [7:0] b [$], input logic p);
    i_tci_i2c_master.edge_cond(1'b1);
    i_tci_i2c_master.wbyte(AW, k);
    foreach (b[i]) i_tci_i2c_master.wbyte(b[i], k);
    if (p) i_tci_i2c_master.edge_cond(1'b0);
  endtask : send
  // repeated start keeps one session; words arrive low byte first
  task automatic rd(input logic [7:0] a, input int w);
    send({a}, 1'b0);
    i_tci_i2c_master.edge_cond(1'b1);
    i_tci_i2c_master.wbyte(AW | 8'h01, k);
    for (int i = 0; i < w; i++) begin
      i_tci_i2c_master.rbyte(rw[i][7:0], 1'b0);
      i_tci_i2c_master.rbyte(rw[i][15:8], i == w - 1);
    end
    i_tci_i2c_master.edge_cond(1'b0);
  endtask : rd
  task automatic give_verdict();
    #1;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // main sequence: streaming, timeout, event gating, forced access, session end, suspend
  initial begin
    tick(5);
    rst_n = 1'b1;
    chk("show_reset", 16'h0001, 16'(show_reset));
    chk("rdy idle", 16'h0000, 16'(rdy_oe));
    d[0] = 16'($random(seed));
    d[1] = 16'($random(seed));
    wait_lvl("cycle window", 0, 1'b1, 250);
    send({8'h20, d[0][7:0], d[0][15:8], d[1][7:0], d[1][15:8]}, 1'b0);
    rd(8'h20, 2);
    chk("word 20", d[0], rw[0]);
    chk("word 21", d[1], rw[1]);
    wait_lvl("stop closes", 0, 1'b0, 10);
    i_tci_i2c_master.edge_cond(1'b1);
    i_tci_i2c_master.wbyte(8'hAA, k);
    i_tci_i2c_master.edge_cond(1'b0);
    chk("foreign ack", 16'h0000, 16'(k));
    send({8'hE0, 8'h00, d[1][7:0], d[1][15:8], d[0][7:0], d[0][15:8]}, 1'b0);
    chk("stretched in", 16'h0001, 16'(rdy_oe));
    rd(8'hE0, 2);
    chk("ext 0", d[1], rw[0]);
    chk("ext 1", d[0], rw[1]);
    // 8 ms timeout stays below the 10 ms cycle
    send({8'h32, 8'h08, 8'h00}, 1'b1);
    wait_lvl("next window", 0, 1'b1, 250);
    for (n = 0; n < 250 && rdy_oe === 1'b1; n++) tick(1);
    chk("timeout span", 16'h0001, 16'(n > 7 * MSC && n <= 8 * MSC + 5));
    wait_lvl("window again", 0, 1'b1, 250);
    send({8'h32, 8'h64, 8'h00}, 1'b1);
    // bus transfers end at any point of the clock; realign before touching settings
    tick(1);
    event_mode_en = 1'b1;
    wait_lvl("flag window", 0, 1'b1, 250);
    send({8'h33, 8'h01, 8'h00}, 1'b1);
    chk("flag cleared", 16'h0000, 16'(show_reset));
    tick(450);
    chk("no event", 16'h0000, 16'(rdy_oe));
    for (int i = 0; i < 6; i++) begin
      e = i - (i > 3);
      for (int on = 0; on < 2; on++) begin
        en[e] = on[0];
        evt[i] = 1'b1;
        tick(1);
        evt[i] = 1'b0;
        if (on == 1) begin
          wait_lvl("event window", 0, 1'b1, 250);
          rd(8'h0F, 1);
          chk("info", {14'h0000, i == 4, i == 3}, rw[0]);
        end
        tick(450);
        chk("quiet", 16'h0000, 16'(rdy_oe));
      end
    end
    send({8'h25, d[1][7:0], d[1][15:8]}, 1'b1);
    rd(8'h25, 1);
    chk("forced word", d[1], rw[0]);
    tick(1);
    comms_req_en = 1'b1;
    comms_end_cmd = 1'b1;
    send({8'hFF, 8'h00}, 1'b1);
    wait_lvl("request window", 0, 1'b1, 250);
    send({8'h26, d[0][7:0], d[0][15:8]}, 1'b1);
    tick(10);
    chk("stop keeps", 16'h0001, 16'(rdy_oe));
    send({8'hFF, 8'h00}, 1'b1);
    wait_lvl("terminate", 0, 1'b0, 10);
    comms_req_en = 1'b0;
    comms_end_cmd = 1'b0;
    send({8'h33, 8'h02, 8'h00}, 1'b1);
    wait_lvl("suspend", 1, 1'b1, 10);
    send({8'h33, 8'h00, 8'h00}, 1'b1);
    wait_lvl("wake", 1, 1'b0, 10);
    send({8'h33, 8'h04, 8'h00}, 1'b1);
    tick(10);
    chk("restart pulse", 16'h0001, 16'(restarts));
    chk("flag again", 16'h0001, 16'(show_reset));
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
